/* File: logic/pmr_ctrl.sv */
// Power mode sequencing and reset source gathering with a sticky cause record.
//
// What this block does
// - The block offers Active, Sleep and Deep Sleep, and in Active every clock runs.
// - Sleep gates the processor clock only, keeps the peripheral clock running and wakes at once on a wake event.
// - Deep Sleep stops the high-speed clock and takes 35 us to return to Active.
// - After power-on no mode is entered until the supply monitor reports good levels.
// - A brown-out from the supply monitor raises a system reset.
// - The watchdog counts low-power oscillator ticks, runs in Deep Sleep and resets on timeout.
// - A watchdog reset is recorded as such in the readable reset-cause register.
// - Power-on, pin and brown-out resets act asynchronously, firmware and watchdog resets through a register; each returns the mode state to known values.
// - The reset-cause record survives the reset it describes.
// - The system reset is held for as long as the external reset pin is low.
// - A firmware reset request is accepted as a reset source.
// - The wake-up interrupt logic stays powered in Deep Sleep and can wake the processor.
`timescale 1ns/1ps
`default_nettype none
module pmr_ctrl
    import pmr_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES   = DEEP_WAKE_CYCLES,
    parameter int unsigned WDOG_TICKS    = WDOG_TIMEOUT_TICKS,
    parameter int unsigned LPO_DIV       = LPO_DIV_CYCLES
) (
    // Clock and power-on reset
    input  wire logic       MCLK,
    input  wire logic       RSTN,
    // Reset sources
    input  wire logic       EXT_RESET_N,
    input  wire logic       SUPPLY_GOOD,
    input  wire logic       BROWN_OUT,
    input  wire logic       SOFT_RESET_REQ,
    // Watchdog control
    input  wire logic       WDOG_ENABLE,
    input  wire logic       WDOG_SERVICE,
    // Mode requests and cause clear
    input  wire logic       SLEEP_REQ,
    input  wire logic       DEEP_REQ,
    input  wire logic       WAKE_EVENT,
    input  wire logic       CAUSE_CLEAR,
    // Outputs
    output var  logic       SYS_RESET_N,
    output var  logic       CPU_CLK_EN,
    output var  logic       HS_CLK_EN,
    output var  logic       PERIPH_CLK_EN,
    output var  logic       WAKEUP_INT_CTRL_ON,
    output var  logic       CPU_WAKE,
    output var  logic [4:0] MODE,
    output var  logic [3:0] RESET_CAUSE
);

    localparam int unsigned WCW = $clog2(WAKE_CYCLES + 1);
    localparam int unsigned SCW = $clog2(RST_STRETCH_CYCLES + 1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        pmr_mode_type mode;
        logic [WCW-1:0] wake_cnt;
        logic       cpu_clk_en;
        logic       hs_clk_en;
        logic       periph_clk_en;
        logic       wic_on;
        logic       cpu_wake;
    } pmr_ctrl_state_type;

    // The stretch is kept apart from the mode state because it sits in the
    // power-on reset domain, while the mode state is cleared by every source.
    typedef struct packed {
        logic           sys_rst_n;
        logic [SCW-1:0] hold_cnt;
    } pmr_stretch_type;

    pmr_ctrl_state_type st_r;
    pmr_ctrl_state_type st_nxt;
    pmr_stretch_type    str_r;
    pmr_stretch_type    str_nxt;
    logic [3:0]         cause_r;
    logic [3:0]         cause_nxt;
    logic               wdog_expire;
    logic               sys_rst_n_int;
    logic               any_src;

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    pmr_wdog #(
        .TIMEOUT_TICKS (WDOG_TICKS),
        .LPO_DIV       (LPO_DIV)
    ) u_wdog (
        .clk     (MCLK),
        .rst_n   (sys_rst_n_int),
        .enable  (WDOG_ENABLE),
        .service (WDOG_SERVICE),
        .expire  (wdog_expire)
    );

    // ----------------------------------------------------------------
    // Reset gathering
    // ----------------------------------------------------------------
    // asynchronous reset combine
    // brown-out resets
    // Combining power-on, pin and brown-out onto the async clear keeps those sources clock-free;
    // registered sources release through the stretch counter below.
    assign sys_rst_n_int = RSTN & EXT_RESET_N & ~BROWN_OUT & str_r.sys_rst_n;

    assign any_src = SOFT_RESET_REQ | wdog_expire;

    // ----------------------------------------------------------------
    // Cause record
    // ----------------------------------------------------------------
    // cause survives reset
    // Only power-on and CAUSE_CLEAR clear it, so software sees the cause after any other reset.
    always_comb begin
        cause_nxt = cause_r;
        if (CAUSE_CLEAR) begin
            cause_nxt = CAUSE_RESET_VAL;
        end
        if (wdog_expire) begin
            cause_nxt[CAUSE_WDOG] = 1'b1;
        end
        if (SOFT_RESET_REQ) begin
            cause_nxt[CAUSE_SOFT] = 1'b1;
        end
        if (!EXT_RESET_N) begin
            cause_nxt[CAUSE_EXT] = 1'b1;
        end
        if (BROWN_OUT) begin
            cause_nxt[CAUSE_BROWN] = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cause_r <= CAUSE_RESET_VAL;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Mode sequencing
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt          = st_r;
        str_nxt         = str_r;
        st_nxt.cpu_wake = 1'b0;
        if (any_src) begin
            // Internal reset stretch so the async clear lasts several cycles.
            str_nxt.sys_rst_n = 1'b0;
            str_nxt.hold_cnt  = SCW'(RST_STRETCH_CYCLES - 1);
        end else if (!str_r.sys_rst_n) begin
            if (str_r.hold_cnt == '0) begin
                str_nxt.sys_rst_n = 1'b1;
            end else begin
                str_nxt.hold_cnt = str_r.hold_cnt - SCW'(1);
            end
        end
        case (st_r.mode)
            PM_POWERUP: begin
                if (SUPPLY_GOOD) begin
                    // clocks start with Active
                    // Enables move with the mode so no cycle shows Active with clocks off.
                    st_nxt.mode          = PM_ACTIVE;
                    st_nxt.cpu_clk_en    = 1'b1;
                    st_nxt.hs_clk_en     = 1'b1;
                    st_nxt.periph_clk_en = 1'b1;
                end
            end
            PM_ACTIVE: begin
                st_nxt.cpu_clk_en    = 1'b1;
                st_nxt.hs_clk_en     = 1'b1;
                st_nxt.periph_clk_en = 1'b1;
                if (DEEP_REQ) begin
                    st_nxt.mode          = PM_DEEP;
                    st_nxt.cpu_clk_en    = 1'b0;
                    st_nxt.hs_clk_en     = 1'b0;
                    st_nxt.periph_clk_en = 1'b0;
                end else if (SLEEP_REQ) begin
                    st_nxt.mode       = PM_SLEEP;
                    st_nxt.cpu_clk_en = 1'b0;
                end
            end
            PM_SLEEP: begin
                if (WAKE_EVENT) begin
                    st_nxt.mode       = PM_ACTIVE;
                    st_nxt.cpu_clk_en = 1'b1;
                    st_nxt.cpu_wake   = 1'b1;
                end
            end
            PM_DEEP: begin
                st_nxt.wic_on = 1'b1;
                if (WAKE_EVENT) begin
                    st_nxt.mode      = PM_WAKING;
                    st_nxt.hs_clk_en = 1'b1;
                    st_nxt.wake_cnt  = WCW'(WAKE_CYCLES - 1);
                end
            end
            PM_WAKING: begin
                if (st_r.wake_cnt == '0) begin
                    st_nxt.mode          = PM_ACTIVE;
                    st_nxt.cpu_clk_en    = 1'b1;
                    st_nxt.periph_clk_en = 1'b1;
                    st_nxt.cpu_wake      = 1'b1;
                end else begin
                    st_nxt.wake_cnt = st_r.wake_cnt - WCW'(1);
                end
            end
            default: begin
                st_nxt.mode = PM_POWERUP;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Mode state registers
    // ----------------------------------------------------------------
    // known state on reset
    always_ff @(posedge MCLK or negedge sys_rst_n_int) begin
        if (!sys_rst_n_int) begin
            st_r.mode          <= PM_POWERUP;
            st_r.wake_cnt      <= '0;
            st_r.cpu_clk_en    <= 1'b0;
            st_r.hs_clk_en     <= 1'b0;
            st_r.periph_clk_en <= 1'b0;
            st_r.wic_on        <= 1'b1;
            st_r.cpu_wake      <= 1'b0;
        end else begin
            st_r.mode          <= st_nxt.mode;
            st_r.wake_cnt      <= st_nxt.wake_cnt;
            st_r.cpu_clk_en    <= st_nxt.cpu_clk_en;
            st_r.hs_clk_en     <= st_nxt.hs_clk_en;
            st_r.periph_clk_en <= st_nxt.periph_clk_en;
            st_r.wic_on        <= st_nxt.wic_on;
            st_r.cpu_wake      <= st_nxt.cpu_wake;
        end
    end

    // ----------------------------------------------------------------
    // Reset stretch registers
    // ----------------------------------------------------------------
    // The stretch flops sit on the power-on reset only, so they
    // can release the internal reset they themselves assert.
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            str_r.sys_rst_n <= 1'b1;
            str_r.hold_cnt  <= '0;
        end else begin
            str_r.sys_rst_n <= str_nxt.sys_rst_n;
            str_r.hold_cnt  <= str_nxt.hold_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            SYS_RESET_N        <= 1'b0;
            CPU_CLK_EN         <= 1'b0;
            HS_CLK_EN          <= 1'b0;
            PERIPH_CLK_EN      <= 1'b0;
            WAKEUP_INT_CTRL_ON <= 1'b1;
            CPU_WAKE           <= 1'b0;
            MODE               <= PM_POWERUP;
            RESET_CAUSE        <= CAUSE_RESET_VAL;
        end else begin
            SYS_RESET_N        <= sys_rst_n_int & (st_r.mode != PM_POWERUP);
            CPU_CLK_EN         <= st_r.cpu_clk_en;
            HS_CLK_EN          <= st_r.hs_clk_en;
            PERIPH_CLK_EN      <= st_r.periph_clk_en;
            WAKEUP_INT_CTRL_ON <= st_r.wic_on;
            CPU_WAKE           <= st_r.cpu_wake;
            MODE               <= st_r.mode;
            RESET_CAUSE        <= cause_r;
        end
    end

endmodule // pmr_ctrl
`default_nettype wire

/* File: logic/pmr_pkg.sv */
// Package with constants and types for the power mode and reset controller.
`default_nettype none
package pmr_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ      = 250_000_000;
    localparam int unsigned DEEP_WAKE_NS     = 35_000;
    localparam int unsigned DEEP_WAKE_CYCLES = (DEEP_WAKE_NS * 1) / 4;
    localparam int unsigned LPO_FREQ_HZ      = 40_000;
    localparam int unsigned LPO_DIV_CYCLES   = CLK_FREQ_HZ / LPO_FREQ_HZ;
    localparam int unsigned WDOG_TIMEOUT_TICKS = 4096;
    localparam int unsigned RST_STRETCH_CYCLES = 16;

    // ----------------------------------------------------------------
    // Reset cause bit positions
    // ----------------------------------------------------------------
    localparam int unsigned CAUSE_WDOG = 0;
    localparam int unsigned CAUSE_SOFT = 1;
    localparam int unsigned CAUSE_EXT  = 2;
    localparam int unsigned CAUSE_BROWN = 3;
    localparam int unsigned CAUSE_W    = 4;
    localparam logic [3:0]  CAUSE_RESET_VAL = 4'h0;

    // ----------------------------------------------------------------
    // Power modes, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        PM_POWERUP = 5'h01,
        PM_ACTIVE  = 5'h02,
        PM_SLEEP   = 5'h04,
        PM_DEEP    = 5'h08,
        PM_WAKING  = 5'h10
    } pmr_mode_type;

endpackage : pmr_pkg
`default_nettype wire

/* File: logic/pmr_wdog.sv */
// Watchdog counter clocked by clk, stepped by a low-power oscillator tick divided down from clk.
`timescale 1ns/1ps
`default_nettype none
module pmr_wdog
    import pmr_pkg::*;
#(
    parameter int unsigned TIMEOUT_TICKS = WDOG_TIMEOUT_TICKS,
    parameter int unsigned LPO_DIV       = LPO_DIV_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic enable,
    input  wire logic service,
    // Result
    output var  logic expire
);

    localparam int unsigned DW = $clog2(LPO_DIV + 1);
    localparam int unsigned TW = $clog2(TIMEOUT_TICKS + 1);

    typedef struct packed {
        logic [DW-1:0] div;
        logic [TW-1:0] cnt;
        logic          expire;
    } pmr_wdog_state_type;

    pmr_wdog_state_type st_r;
    pmr_wdog_state_type st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.expire = 1'b0;
        if (st_r.div == DW'(LPO_DIV - 1)) begin
            st_nxt.div = '0;
        end else begin
            st_nxt.div = st_r.div + DW'(1);
        end
        if (!enable || service) begin
            st_nxt.cnt = '0;
        end else if (st_r.div == DW'(LPO_DIV - 1)) begin
            if (st_r.cnt == TW'(TIMEOUT_TICKS - 1)) begin
                st_nxt.expire = 1'b1;
                st_nxt.cnt    = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + TW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expire = st_r.expire;

endmodule // pmr_wdog
`default_nettype wire

/* File: testbench/pmr_ctrl_checker.sv */
// Concurrent checks on the ports of the power mode and reset controller.
`timescale 1ns/1ps
`default_nettype none
module pmr_ctrl_checker
    import pmr_pkg::*;
#(
    parameter int WAKE_CYCLES = 4
) (
    // Clock and reset
    input wire logic       MCLK,
    input wire logic       RSTN,
    // Watched inputs
    input wire logic       EXT_RESET_N,
    input wire logic       SUPPLY_GOOD,
    input wire logic       BROWN_OUT,
    input wire logic       SOFT_RESET_REQ,
    input wire logic       CAUSE_CLEAR,
    // Watched outputs
    input wire logic       SYS_RESET_N,
    input wire logic       CPU_CLK_EN,
    input wire logic       HS_CLK_EN,
    input wire logic       PERIPH_CLK_EN,
    input wire logic       WAKEUP_INT_CTRL_ON,
    input wire logic       CPU_WAKE,
    input wire logic [4:0] MODE,
    input wire logic [3:0] RESET_CAUSE
);
    // A little slack on the wake count covers the two stage output lag.
    localparam int WHI = WAKE_CYCLES + 2;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    property p_wic; WAKEUP_INT_CTRL_ON; endproperty
    a_wic: assert property (p_wic) else $error("wake logic off");
    property p_ext; !EXT_RESET_N |=> !SYS_RESET_N; endproperty
    a_ext: assert property (p_ext) else $error("pin reset missed");
    property p_brown; BROWN_OUT |=> !SYS_RESET_N; endproperty
    a_brown: assert property (p_brown) else $error("brown-out reset missed");
    property p_extc; !EXT_RESET_N |-> ##2 RESET_CAUSE[CAUSE_EXT]; endproperty
    a_extc: assert property (p_extc) else $error("pin cause missing");
    property p_softc; SOFT_RESET_REQ |-> ##[1:20] RESET_CAUSE[CAUSE_SOFT]; endproperty
    a_softc: assert property (p_softc) else $error("soft cause missing");
    property p_sticky;
        !CAUSE_CLEAR && !$past(CAUSE_CLEAR)
            |=> (RESET_CAUSE & $past(RESET_CAUSE)) == $past(RESET_CAUSE);
    endproperty
    a_sticky: assert property (p_sticky) else $error("cause flag lost");
    property p_sleep; MODE == PM_SLEEP |-> !CPU_CLK_EN && PERIPH_CLK_EN; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
    property p_deep; MODE == PM_DEEP |-> !HS_CLK_EN && !CPU_CLK_EN; endproperty
    a_deep: assert property (p_deep) else $error("deep clocks wrong");
    property p_act;
        MODE == PM_ACTIVE && SYS_RESET_N |-> CPU_CLK_EN && HS_CLK_EN && PERIPH_CLK_EN;
    endproperty
    a_act: assert property (p_act) else $error("active clocks off");
    property p_sup; !SUPPLY_GOOD && MODE == PM_POWERUP |=> MODE == PM_POWERUP; endproperty
    a_sup: assert property (p_sup) else $error("left powerup early");
    property p_wake;
        $rose(MODE == PM_WAKING) |-> (MODE == PM_WAKING) [*3] ##[0:WHI] MODE == PM_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) else $error("deep wake time wrong");
    property p_cwake;
        CPU_WAKE == (MODE == PM_ACTIVE && ($past(MODE) == PM_SLEEP || $past(MODE) == PM_WAKING));
    endproperty
    a_cwake: assert property (p_cwake) else $error("wake pulse wrong");
endmodule // pmr_ctrl_checker
bind pmr_ctrl pmr_ctrl_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
    .MCLK(MCLK), .RSTN(RSTN), .EXT_RESET_N(EXT_RESET_N), .SUPPLY_GOOD(SUPPLY_GOOD),
    .BROWN_OUT(BROWN_OUT), .SOFT_RESET_REQ(SOFT_RESET_REQ), .CAUSE_CLEAR(CAUSE_CLEAR),
    .SYS_RESET_N(SYS_RESET_N), .CPU_CLK_EN(CPU_CLK_EN), .HS_CLK_EN(HS_CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .WAKEUP_INT_CTRL_ON(WAKEUP_INT_CTRL_ON),
    .CPU_WAKE(CPU_WAKE), .MODE(MODE), .RESET_CAUSE(RESET_CAUSE));
`default_nettype wire

/* File: testbench/pmr_partner.sv */
// Model of the external reset pin driver and the wake-up source.
`timescale 1ns/1ps
`default_nettype none
module pmr_partner (
    // Clock
    input  wire logic clk,
    // Pin and wake request
    output var  logic ext_reset_n,
    output var  logic wake_event
);
    initial begin
        ext_reset_n = 1'b1;
        wake_event  = 1'b0;
    end
    // pin held low
    // The task drives the pin high again on release, so a released pin reads high.
    task automatic pin_reset(input int cycles);
        @(posedge clk) ext_reset_n <= 1'b0;
        repeat (cycles) @(posedge clk);
        ext_reset_n <= 1'b1;
    endtask
    task automatic wake();
        @(posedge clk) wake_event <= 1'b1;
        @(posedge clk) wake_event <= 1'b0;
    endtask
endmodule // pmr_partner
`default_nettype wire

/* File: testbench/power_mode_reset_control_tb.sv */
// Self-checking bench for the power mode and reset controller.
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_control_tb;
    import pmr_pkg::*;
    typedef struct {logic s; logic d; logic [4:0] m; logic c; logic h; logic p;} pmr_row_type;
    // Short counts keep the run brief; expectations use the same values.
    localparam int WCYC = 4;
    logic MCLK, RSTN, SUPPLY_GOOD, BROWN_OUT, SOFT_RESET_REQ, WDOG_ENABLE, WDOG_SERVICE;
    logic SLEEP_REQ, DEEP_REQ, CAUSE_CLEAR, ext_n, wake;
    logic SYS_RESET_N, CPU_CLK_EN, HS_CLK_EN, PERIPH_CLK_EN, WIC_ON, CPU_WAKE;
    logic [4:0] MODE;
    logic [3:0] RESET_CAUSE;
    int fails = 0;
    int tests_run = 0;
    int n;
    pmr_row_type rows [4];
    pmr_partner u_p (.clk(MCLK), .ext_reset_n(ext_n), .wake_event(wake));
    pmr_ctrl #(.WAKE_CYCLES(WCYC), .WDOG_TICKS(4), .LPO_DIV(2)) DUT (
        .MCLK(MCLK), .RSTN(RSTN), .EXT_RESET_N(ext_n), .SUPPLY_GOOD(SUPPLY_GOOD),
        .BROWN_OUT(BROWN_OUT), .SOFT_RESET_REQ(SOFT_RESET_REQ), .WDOG_ENABLE(WDOG_ENABLE),
        .WDOG_SERVICE(WDOG_SERVICE), .SLEEP_REQ(SLEEP_REQ), .DEEP_REQ(DEEP_REQ),
        .WAKE_EVENT(wake), .CAUSE_CLEAR(CAUSE_CLEAR), .SYS_RESET_N(SYS_RESET_N),
        .CPU_CLK_EN(CPU_CLK_EN), .HS_CLK_EN(HS_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
        .WAKEUP_INT_CTRL_ON(WIC_ON), .CPU_WAKE(CPU_WAKE), .MODE(MODE),
        .RESET_CAUSE(RESET_CAUSE));
    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end
    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic wt_mode(input logic [4:0] m, output int k);
        k = 0;
        while (MODE !== m && k < 200) begin
            @(posedge MCLK);
            #1;
            k++;
        end
        chk("MODE", m, MODE);
    endtask
    task automatic wt_sr(input logic v);
        int k;
        k = 0;
        while (SYS_RESET_N !== v && k < 200) begin
            @(posedge MCLK);
            #1;
            k++;
        end
        chk("SYS_RESET_N", {4'h0, v}, {4'h0, SYS_RESET_N});
    endtask
    task automatic clr();
        @(posedge MCLK) CAUSE_CLEAR <= 1'b1;
        @(posedge MCLK) CAUSE_CLEAR <= 1'b0;
        @(posedge MCLK);
        #1;
        chk("RESET_CAUSE", 5'h00, {1'b0, RESET_CAUSE});
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        test_done();
    end
    initial begin
        {RSTN, SUPPLY_GOOD, BROWN_OUT, SOFT_RESET_REQ, WDOG_ENABLE} = 5'h00;
        {WDOG_SERVICE, SLEEP_REQ, DEEP_REQ, CAUSE_CLEAR} = 4'h0;
        rows[0] = '{1'b1, 1'b0, PM_SLEEP, 1'b0, 1'b1, 1'b1};
        rows[1] = '{1'b0, 1'b1, PM_DEEP, 1'b0, 1'b0, 1'b0};
        rows[2] = '{1'b1, 1'b1, PM_DEEP, 1'b0, 1'b0, 1'b0};
        rows[3] = '{1'b0, 1'b0, PM_ACTIVE, 1'b1, 1'b1, 1'b1};
        repeat (10) @(posedge MCLK);
        #1;
        chk("MODE", PM_POWERUP, MODE);
        chk("CAUSE", 5'h00, {1'b0, RESET_CAUSE});
        @(posedge MCLK) RSTN <= 1'b1;
        repeat (8) @(posedge MCLK);
        #1;
        chk("MODE", PM_POWERUP, MODE);
        @(posedge MCLK) SUPPLY_GOOD <= 1'b1;
        wt_sr(1'b1);
        foreach (rows[i]) begin
            @(posedge MCLK) {SLEEP_REQ, DEEP_REQ} <= {rows[i].s, rows[i].d};
            @(posedge MCLK) {SLEEP_REQ, DEEP_REQ} <= 2'b00;
            repeat (2) @(posedge MCLK);
            #1;
            chk("MODE", rows[i].m, MODE);
            chk("CLKS", {2'b00, rows[i].c, rows[i].h, rows[i].p},
                {2'b00, CPU_CLK_EN, HS_CLK_EN, PERIPH_CLK_EN});
            if (rows[i].m !== PM_ACTIVE) begin
                u_p.wake();
                wt_mode(PM_ACTIVE, n);
                chk("wake_len", 5'h01, {4'h0, rows[i].d ? n >= WCYC : n <= 3});
            end
        end
        fork
            u_p.pin_reset(20);
            begin
                repeat (12) @(posedge MCLK);
                #1;
                chk("SYS_RESET_N", 5'h00, {4'h0, SYS_RESET_N});
            end
        join
        wt_sr(1'b1);
        chk("CAUSE", 5'h04, {1'b0, RESET_CAUSE});
        clr();
        @(posedge MCLK) BROWN_OUT <= 1'b1;
        repeat (3) @(posedge MCLK);
        #1;
        chk("SYS_RESET_N", 5'h00, {4'h0, SYS_RESET_N});
        @(posedge MCLK) BROWN_OUT <= 1'b0;
        wt_sr(1'b1);
        chk("CAUSE", 5'h08, {1'b0, RESET_CAUSE});
        clr();
        @(posedge MCLK) SOFT_RESET_REQ <= 1'b1;
        @(posedge MCLK) SOFT_RESET_REQ <= 1'b0;
        wt_sr(1'b0);
        wt_sr(1'b1);
        chk("CAUSE", 5'h02, {1'b0, RESET_CAUSE});
        clr();
        @(posedge MCLK) WDOG_ENABLE <= 1'b1;
        repeat (10) begin
            @(posedge MCLK) WDOG_SERVICE <= 1'b1;
            @(posedge MCLK) WDOG_SERVICE <= 1'b0;
            @(posedge MCLK);
        end
        #1;
        chk("CAUSE", 5'h00, {1'b0, RESET_CAUSE});
        @(posedge MCLK) DEEP_REQ <= 1'b1;
        @(posedge MCLK) DEEP_REQ <= 1'b0;
        wt_sr(1'b0);
        @(posedge MCLK) WDOG_ENABLE <= 1'b0;
        wt_sr(1'b1);
        chk("CAUSE", 5'h01, {1'b0, RESET_CAUSE});
        @(posedge MCLK) RSTN <= 1'b0;
        #1;
        chk("MODE", PM_POWERUP, MODE);
        chk("CAUSE", 5'h00, {1'b0, RESET_CAUSE});
        repeat (2) @(posedge MCLK);
        RSTN <= 1'b1;
        wt_sr(1'b1);
        test_done();
    end
endmodule // power_mode_reset_control_tb
`default_nettype wire
